// ==== common/fws_pkg.sv ====
/*
  fws_pkg: constants, register map and carrier types for the host-side
  flash status-polling controller.
  assumes a single 250 MHz clock and an asynchronous parallel flash whose
  status bits appear on the data pins during embedded operations.
*/
// What this block does
// - host writes the reset command after seeing the fail flag at 1
// - host spacing added sector commands under 50 us may skip flag check
// - host confirms acceptance by polling before reading the window flag
// - host reads window flag before and after each added sector command it does not skip
// - host polls status at a valid address inside a selected sector
package fws_pkg;

  // pin, register port, counter and event widths
  localparam int AW  = 20;
  localparam int DW  = 16;
  localparam int RAW = 8;
  localparam int RDW = 32;
  localparam int CW  = 8;
  localparam int SW  = 16;
  localparam int EVW = 4;

  // timing
  localparam int CLK_PS   = 4000;
  localparam int ACC_NS   = 90;
  localparam int OEH_NS   = 30;
  localparam int WIN_US   = 50;
  localparam int SYNC_LAT = 4;
  localparam int ACC_CYC  = (ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OEH_CYC  = (OEH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_CYC   = ACC_CYC + SYNC_LAT;
  localparam int WIN_CYC  = (WIN_US * 1000 * 1000) / CLK_PS;

  // status bit positions on the flash data pins
  localparam int CPL_BIT = 7;
  localparam int TGL_BIT = 6;
  localparam int TLF_BIT = 5;
  localparam int WIN_BIT = 3;
  localparam int STG_BIT = 2;

  // register byte offsets
  localparam logic [RAW-1:0] REG_CMD   = 8'h00;
  localparam logic [RAW-1:0] REG_ADDR  = 8'h04;
  localparam logic [RAW-1:0] REG_WDATA = 8'h08;
  localparam logic [RAW-1:0] REG_RDATA = 8'h0C;
  localparam logic [RAW-1:0] REG_STAT  = 8'h10;
  localparam logic [RAW-1:0] REG_IRQ   = 8'h14;
  localparam logic [RAW-1:0] REG_MASK  = 8'h18;
  localparam logic [RAW-1:0] REG_RSTW  = 8'h1C;

  // command register fields
  localparam int OP_W     = 3;
  localparam int SKIP_BIT = 4;

  // status register fields
  localparam int ST_BUSY  = 0;
  localparam int ST_FAIL  = 1;
  localparam int ST_WIN   = 2;
  localparam int ST_RB    = 3;
  localparam int ST_STGL  = 4;
  localparam int ST_SPACE = 5;

  // event bits of interrupt status and mask
  localparam int EV_DONE   = 0;
  localparam int EV_FAIL   = 1;
  localparam int EV_REFUSE = 2;
  localparam int EV_LOST   = 3;

  typedef enum logic [OP_W-1:0] {
    OP_NOP, OP_WRITE, OP_READ, OP_POLL, OP_SECT, OP_RESET, OP_CONFIRM
  } fws_op_t;

  typedef struct packed {
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } fws_req_t;

  typedef struct packed {
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic          dq_oe;
  } fws_pins_t;

endpackage

// ==== hdl/fws_sync.sv ====
/*
  fws_sync: three-stage input synchroniser; output follows once the
  second and third stages agree.
  assumes input is asynchronous to clk.
*/
module fws_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import fws_pkg::*;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (s2_r == s3_r)
      q_nxt = s3_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ==== hdl/fws_cycle.sv ====
/*
  fws_cycle: runs one flash read or write bus cycle on the pins.
  assumes dq_in is already synchronised; a go while busy is ignored.
*/
module fws_cycle
#(
  parameter int WE_NS = 50
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // request
  input  wire logic                 go,
  input  wire fws_pkg::fws_req_t    req,
  output logic                      done,
  output logic [fws_pkg::DW-1:0]    rdata,
  // flash pins
  input  wire logic [fws_pkg::DW-1:0] dq_in,
  output fws_pkg::fws_pins_t        pins
);
  import fws_pkg::*;

  localparam int WE_CYC = (WE_NS * 1000 + CLK_PS - 1) / CLK_PS;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_GAP} fws_cst_t;

  fws_cst_t      st_r;
  fws_cst_t      st_nxt;
  fws_pins_t     pins_r;
  fws_pins_t     pins_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic          done_r;
  logic          done_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    pins_nxt  = pins_r;
    cnt_nxt   = cnt_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    case (st_r)
      C_IDLE:
        if (go)
        begin
          pins_nxt.addr  = req.addr;
          pins_nxt.dq    = req.data;
          pins_nxt.dq_oe = req.wr;
          pins_nxt.ce_n  = 1'b0;
          st_nxt         = C_SETUP;
        end
      C_SETUP:
      begin
        pins_nxt.oe_n = pins_r.dq_oe;
        pins_nxt.we_n = ~pins_r.dq_oe ? 1'b1 : 1'b0;
        cnt_nxt = pins_r.dq_oe ? CW'(WE_CYC) : CW'(RD_CYC);
        st_nxt  = C_PULSE;
      end
      C_PULSE:
        if (cnt_r == CW'(1))
        begin
          if (!pins_r.dq_oe)
            rdata_nxt = dq_in;
          pins_nxt.we_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          cnt_nxt = CW'(OEH_CYC);
          st_nxt  = C_GAP;
        end
        else
          cnt_nxt = cnt_r - CW'(1);
      default:
        if (cnt_r == CW'(1))
        begin
          pins_nxt.ce_n  = 1'b1;
          pins_nxt.dq_oe = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = C_IDLE;
        end
        else
          cnt_nxt = cnt_r - CW'(1);
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r    <= C_IDLE;
      pins_r  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      cnt_r   <= '0;
      rdata_r <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      pins_r  <= pins_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
    end
  end

  assign pins  = pins_r;
  assign rdata = rdata_r;
  assign done  = done_r;

endmodule

// ==== hdl/fws_ctrl.sv ====
/*
  fws_ctrl: host controller that drives a parallel flash through its pins,
  runs status polling for program and erase, and reports via registers.
  assumes software writes the unlock and command words as raw writes;
  the controller adds polling, window checks and the reset on failure.
*/
module fws_ctrl
#(
  parameter int WINDOW_CYC = fws_pkg::WIN_CYC
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // register port
  input  wire logic [fws_pkg::RAW-1:0] reg_addr,
  input  wire logic [fws_pkg::RDW-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [fws_pkg::RDW-1:0] reg_rdata,
  output logic                         irq,
  // flash pins
  output logic      [fws_pkg::AW-1:0]  fl_addr,
  output logic      [fws_pkg::DW-1:0]  fl_dq_out,
  output logic                         fl_dq_oe,
  input  wire logic [fws_pkg::DW-1:0]  fl_dq_in,
  output logic                         fl_ce_n,
  output logic                         fl_oe_n,
  output logic                         fl_we_n,
  input  wire logic                    fl_ready_busy
);
  import fws_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_WR, S_READ, S_RD1, S_RD2, S_RDA, S_RDB,
    S_RST, S_PRE, S_POST, S_WINR
  } fws_st_t;

  // sequencer state
  fws_st_t        state_r;
  fws_st_t        state_nxt;
  fws_op_t        op_r;
  fws_op_t        op_nxt;
  logic           skip_r;
  logic           skip_nxt;
  logic           pend_r;
  logic           pend_nxt;
  logic [DW-1:0]  d1_r;
  logic [DW-1:0]  d1_nxt;
  logic [DW-1:0]  rdata_r;
  logic [DW-1:0]  rdata_nxt;
  logic           fail_r;
  logic           fail_nxt;
  logic           win_r;
  logic           win_nxt;
  logic           stgl_r;
  logic           stgl_nxt;
  logic [EVW-1:0] ev;
  logic           space_rst;
  // register state
  logic [AW-1:0]  addr_r;
  logic [AW-1:0]  addr_nxt;
  logic [DW-1:0]  wdata_r;
  logic [DW-1:0]  wdata_nxt;
  logic [DW-1:0]  rstw_r;
  logic [DW-1:0]  rstw_nxt;
  logic [EVW-1:0] mask_r;
  logic [EVW-1:0] mask_nxt;
  logic [EVW-1:0] irqs_r;
  logic [EVW-1:0] irqs_nxt;
  logic [RDW-1:0] rd_r;
  logic [RDW-1:0] rd_nxt;
  logic           irq_r;
  logic           irq_nxt;
  logic [SW-1:0]  space_r;
  logic [SW-1:0]  space_nxt;
  // glue
  logic           space_ok;
  logic           cmd_wr;
  fws_op_t        cmd_op;
  logic           cyc_go;
  logic           cyc_done;
  logic [DW-1:0]  cyc_rdata;
  fws_req_t       cyc_req;
  fws_pins_t      pins;
  logic [DW-1:0]  dq_s;
  logic           rb_s;
  logic [RDW-1:0] stat;

  // bit flips between two successive status reads
  function automatic logic flipped(input logic [DW-1:0] a,
                                   input logic [DW-1:0] b,
                                   input int            pos);
    flipped = a[pos] ^ b[pos];
  endfunction

  fws_sync #(.W(DW)) u_dq_sync
  (
    .clk (clk),
    .rst (rst),
    .d   (fl_dq_in),
    .q   (dq_s)
  );

  fws_sync #(.W(1)) u_rb_sync
  (
    .clk (clk),
    .rst (rst),
    .d   (fl_ready_busy),
    .q   (rb_s)
  );

  fws_cycle u_cycle
  (
    .clk   (clk),
    .rst   (rst),
    .go    (cyc_go),
    .req   (cyc_req),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .dq_in (dq_s),
    .pins  (pins)
  );

  assign cmd_op   = fws_op_t'(reg_wdata[OP_W-1:0]);
  assign cmd_wr   = reg_wr && (reg_addr == REG_CMD) && (state_r == S_IDLE);
  assign space_ok = space_r < SW'(WINDOW_CYC);
  assign cyc_go   = (state_r != S_IDLE) && !pend_r;

  // every cycle uses the software address, inside the selected sector
  always_comb
  begin
    cyc_req.wr   = (state_r == S_WR) || (state_r == S_RST);
    cyc_req.addr = addr_r;
    cyc_req.data = (state_r == S_RST) ? rstw_r : wdata_r;
  end

  always_comb
  begin
    state_nxt = state_r;
    op_nxt    = op_r;
    skip_nxt  = skip_r;
    pend_nxt  = pend_r;
    d1_nxt    = d1_r;
    rdata_nxt = rdata_r;
    fail_nxt  = fail_r;
    win_nxt   = win_r;
    stgl_nxt  = stgl_r;
    ev        = '0;
    space_rst = 1'b0;
    if (cyc_go)
      pend_nxt = 1'b1;
    if (cyc_done)
      pend_nxt = 1'b0;
    case (state_r)
      S_IDLE:
        if (cmd_wr)
        begin
          op_nxt   = cmd_op;
          skip_nxt = reg_wdata[SKIP_BIT] && space_ok;
          case (cmd_op)
            OP_WRITE:
              state_nxt = S_WR;
            OP_READ:
              state_nxt = S_READ;
            OP_POLL, OP_CONFIRM:
            begin
              // plain poll serves chip erase: no window read there
              fail_nxt  = 1'b0;
              state_nxt = S_RD1;
            end
            OP_SECT:
              state_nxt = (reg_wdata[SKIP_BIT] && space_ok) ? S_WR : S_PRE;
            OP_RESET:
            begin
              fail_nxt  = 1'b0;
              state_nxt = S_RST;
            end
            default:
              state_nxt = S_IDLE;
          endcase
        end
      S_WR:
        if (cyc_done)
        begin
          if (op_r == OP_SECT)
          begin
            space_rst = 1'b1;
            state_nxt = skip_r ? S_IDLE : S_POST;
            ev[EV_DONE] = skip_r;
          end
          else
          begin
            ev[EV_DONE] = 1'b1;
            state_nxt   = S_IDLE;
          end
        end
      S_READ:
        if (cyc_done)
        begin
          rdata_nxt   = cyc_rdata;
          ev[EV_DONE] = 1'b1;
          state_nxt   = S_IDLE;
        end
      S_RD1:
        if (cyc_done)
        begin
          d1_nxt    = cyc_rdata;
          state_nxt = S_RD2;
        end
      S_RD2:
        if (cyc_done)
        begin
          rdata_nxt = cyc_rdata;
          d1_nxt    = cyc_rdata;
          stgl_nxt  = flipped(d1_r, cyc_rdata, STG_BIT);
          if (op_r == OP_CONFIRM)
          begin
            // accepted once busy shows: toggling or complement at 0
            if (flipped(d1_r, cyc_rdata, TGL_BIT) ||
                !cyc_rdata[CPL_BIT])
              state_nxt = S_WINR;
            else
            begin
              ev[EV_REFUSE] = 1'b1;
              state_nxt     = S_IDLE;
            end
          end
          else if (!flipped(d1_r, cyc_rdata, TGL_BIT))
          begin
            ev[EV_DONE] = 1'b1;
            state_nxt   = S_IDLE;
          end
          else if (cyc_rdata[TLF_BIT])
            state_nxt = S_RDA;
        end
      S_RDA:
        if (cyc_done)
        begin
          d1_nxt    = cyc_rdata;
          state_nxt = S_RDB;
        end
      S_RDB:
        if (cyc_done)
        begin
          rdata_nxt = cyc_rdata;
          // toggle may stop just as the fail flag rises
          if (!flipped(d1_r, cyc_rdata, TGL_BIT))
          begin
            ev[EV_DONE] = 1'b1;
            state_nxt   = S_IDLE;
          end
          else
          begin
            fail_nxt  = 1'b1;
            state_nxt = S_RST;
          end
        end
      S_RST:
        if (cyc_done)
        begin
          ev[EV_FAIL] = fail_r;
          ev[EV_DONE] = ~fail_r;
          state_nxt   = S_IDLE;
        end
      S_PRE:
        if (cyc_done)
        begin
          win_nxt = cyc_rdata[WIN_BIT];
          if (cyc_rdata[WIN_BIT])
          begin
            ev[EV_REFUSE] = 1'b1;
            state_nxt     = S_IDLE;
          end
          else
            state_nxt = S_WR;
        end
      S_POST:
        if (cyc_done)
        begin
          win_nxt       = cyc_rdata[WIN_BIT];
          ev[EV_LOST]   = cyc_rdata[WIN_BIT];
          ev[EV_DONE]   = 1'b1;
          state_nxt     = S_IDLE;
        end
      default:
        if (cyc_done)
        begin
          win_nxt     = cyc_rdata[WIN_BIT];
          ev[EV_DONE] = 1'b1;
          state_nxt   = S_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      op_r    <= OP_NOP;
      skip_r  <= 1'b0;
      pend_r  <= 1'b0;
      d1_r    <= '0;
      rdata_r <= '0;
      fail_r  <= 1'b0;
      win_r   <= 1'b0;
      stgl_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      skip_r  <= skip_nxt;
      pend_r  <= pend_nxt;
      d1_r    <= d1_nxt;
      rdata_r <= rdata_nxt;
      fail_r  <= fail_nxt;
      win_r   <= win_nxt;
      stgl_r  <= stgl_nxt;
    end
  end

  // status word, ready/busy shown as synchronised
  always_comb
  begin
    stat           = '0;
    stat[ST_BUSY]  = state_r != S_IDLE;
    stat[ST_FAIL]  = fail_r;
    stat[ST_WIN]   = win_r;
    stat[ST_RB]    = rb_s;
    stat[ST_STGL]  = stgl_r;
    stat[ST_SPACE] = space_ok;
  end

  always_comb
  begin
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    rstw_nxt  = rstw_r;
    mask_nxt  = mask_r;
    rd_nxt    = '0;
    irqs_nxt  = irqs_r;
    if (reg_wr && state_r == S_IDLE)
    begin
      if (reg_addr == REG_ADDR)
        addr_nxt = reg_wdata[AW-1:0];
      else if (reg_addr == REG_WDATA)
        wdata_nxt = reg_wdata[DW-1:0];
      else if (reg_addr == REG_RSTW)
        rstw_nxt = reg_wdata[DW-1:0];
    end
    if (reg_wr && reg_addr == REG_MASK)
      mask_nxt = reg_wdata[EVW-1:0];
    if (reg_rd)
    begin
      if (reg_addr == REG_CMD)
        rd_nxt = RDW'(op_r);
      else if (reg_addr == REG_ADDR)
        rd_nxt = RDW'(addr_r);
      else if (reg_addr == REG_WDATA)
        rd_nxt = RDW'(wdata_r);
      else if (reg_addr == REG_RDATA)
        rd_nxt = RDW'(rdata_r);
      else if (reg_addr == REG_STAT)
        rd_nxt = stat;
      else if (reg_addr == REG_IRQ)
      begin
        rd_nxt   = RDW'(irqs_r);
        irqs_nxt = '0;
      end
      else if (reg_addr == REG_MASK)
        rd_nxt = RDW'(mask_r);
      else if (reg_addr == REG_RSTW)
        rd_nxt = RDW'(rstw_r);
    end
    // new events win over a clearing read
    irqs_nxt = irqs_nxt | ev;
    irq_nxt  = |(irqs_nxt & mask_nxt);
    if (space_rst)
      space_nxt = '0;
    else if (space_ok)
      space_nxt = space_r + SW'(1);
    else
      space_nxt = space_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r  <= '0;
      wdata_r <= '0;
      rstw_r  <= '0;
      mask_r  <= '0;
      irqs_r  <= '0;
      rd_r    <= '0;
      irq_r   <= 1'b0;
      space_r <= SW'(WINDOW_CYC);
    end
    else
    begin
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      rstw_r  <= rstw_nxt;
      mask_r  <= mask_nxt;
      irqs_r  <= irqs_nxt;
      rd_r    <= rd_nxt;
      irq_r   <= irq_nxt;
      space_r <= space_nxt;
    end
  end

  assign reg_rdata = rd_r;
  assign irq       = irq_r;
  assign fl_addr   = pins.addr;
  assign fl_dq_out = pins.dq;
  assign fl_dq_oe  = pins.dq_oe;
  assign fl_ce_n   = pins.ce_n;
  assign fl_oe_n   = pins.oe_n;
  assign fl_we_n   = pins.we_n;

endmodule

// ==== sim/fws_ctrl_assertions.sv ====
/*
  fws_ctrl_chk: pin and register-port timing checks for fws_ctrl.
  assumes it is bound into fws_ctrl and sees only its ports.
*/
module fws_ctrl_chk
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // register port
  input wire logic                    reg_rd,
  input wire logic [fws_pkg::RDW-1:0] reg_rdata,
  // flash pins
  input wire logic [fws_pkg::AW-1:0]  fl_addr,
  input wire logic [fws_pkg::DW-1:0]  fl_dq_out,
  input wire logic                    fl_dq_oe,
  input wire logic                    fl_ce_n,
  input wire logic                    fl_oe_n,
  input wire logic                    fl_we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_strobe_excl: assert property (!(!fl_oe_n && !fl_we_n))
    else $error("oe and we low together");
  chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside answer cycle");
  chk_we_drives: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write pulse without driven data");
  chk_oe_floats: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n)
    else $error("read pulse while driving data");
  chk_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*8])
    else $error("write pulse too short");
  chk_oe_hold: assert property ($rose(fl_oe_n) |-> (fl_oe_n && !fl_ce_n) [*8])
    else $error("select released too soon after read");
  chk_read_span: assert property
    ($fell(fl_oe_n) |-> !fl_oe_n [*8] ##[12:22] $rose(fl_oe_n))
    else $error("read pulse length wrong");
  chk_addr_steady: assert property
    (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
    else $error("address moved inside a cycle");
  chk_dq_steady: assert property (!fl_we_n |-> $stable(fl_dq_out))
    else $error("write data moved during pulse");
endmodule

bind fws_ctrl fws_ctrl_chk chk_u (.clk(clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n));

// ==== sim/fws_flash_model.sv ====
/*
  fws_flash_model: behavioural flash with status bits and erase window.
  assumes the bench starts operations through the start task.
*/
module fws_flash_model
#(
  parameter logic [fws_pkg::DW-1:0] RST_W  = 16'h00E1,
  parameter logic [fws_pkg::DW-1:0] KEY    = 16'h5A5A,
  parameter int                     WIN_NS = 2000
)
(
  // strobes and address
  input  wire logic                   ce_n,
  input  wire logic                   oe_n,
  input  wire logic                   we_n,
  input  wire logic [fws_pkg::AW-1:0] addr,
  // split data pins
  input  wire logic [fws_pkg::DW-1:0] dq_w,
  input  wire logic                   dq_oe,
  output logic      [fws_pkg::DW-1:0] dq_r,
  // open-drain busy, high pulls low
  output logic                        rb_low
);
  timeunit 1ns;
  timeprecision 1ps;
  import fws_pkg::*;
  logic          busy, fail, ers, tgl, stg;
  logic [DW-1:0] last, wr_last;
  int            left;
  realtime       win_end;
  realtime       addr_t;
  localparam realtime SLEEP_NS = ACC_NS + 50;

  assign rb_low = busy;

  // address change wakes the part; a still address lets it nap
  always @(addr)
    addr_t = $realtime;

  function automatic logic asleep();
    return ($realtime - addr_t) >= SLEEP_NS;
  endfunction

  task automatic start(input logic f, input logic e, input int n);
    busy    = 1'b1;
    fail    = f;
    ers     = e;
    left    = n;
    win_end = $realtime + WIN_NS;
  endtask

  initial
  begin
    {busy, fail, ers, tgl, stg} = '0;
    last    = '0;
    wr_last = '0;
    left    = 0;
    win_end = 0;
    addr_t  = 0;
    dq_r    = 16'hFFFF;
  end

  always @(negedge oe_n)
    if (!ce_n)
    begin
      last = addr[DW-1:0] ^ KEY;
      if (busy)
      begin
        last          = 16'h0000;
        last[TGL_BIT] = tgl;
        last[TLF_BIT] = fail;
        last[WIN_BIT] = ers && $realtime >= win_end;
        last[STG_BIT] = stg;
        tgl = ~tgl;
        stg = stg ^ ers;
        left--;
        busy = fail || ers || left > 0;
      end
      dq_r = last;
    end

  // released bus shows the inverse, not a held value
  always @(posedge oe_n or posedge ce_n)
    dq_r = ~last;

  always @(posedge we_n)
    if (!ce_n && dq_oe)
    begin
      wr_last = dq_w;
      if (dq_w == RST_W)
      begin
        busy = 1'b0;
        fail = 1'b0;
        ers  = 1'b0;
      end
      else if (ers && $realtime < win_end)
        win_end = $realtime + WIN_NS;
    end
endmodule

// ==== sim/tb_top.sv ====
/*
  tb_top: self-checking bench for fws_ctrl against the flash model.
  assumes checker and flash model are compiled before it.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fws_pkg::*;
  localparam logic [DW-1:0] RST_W = 16'h00E1;
  localparam logic [DW-1:0] KEY   = 16'h5A5A;
  logic           clk, rst, reg_wr, reg_rd, irq, rd_d, rb_low, vi;
  logic           fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic [RAW-1:0] reg_addr;
  logic [RDW-1:0] reg_wdata, reg_rdata, v, a, lfsr;
  logic [AW-1:0]  fl_addr;
  logic [DW-1:0]  fl_dq_out, dq_r;
  logic [63:0]    expq[$];
  logic [63:0]    ent;
  int             fails, checks_done, cyc;

  fws_ctrl #(.WINDOW_CYC(200)) dut_u (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(fl_dq_oe ? fl_dq_out : dq_r), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_ready_busy(!rb_low));

  fws_flash_model #(.RST_W(RST_W), .KEY(KEY)) flash_u (.ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr), .dq_w(fl_dq_out),
    .dq_oe(fl_dq_oe), .dq_r(dq_r), .rb_low(rb_low));

  always #2 clk = ~clk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one register access; reads note their expectation
  task automatic bus(input logic w, input logic [RAW-1:0] ad,
                     input logic [RDW-1:0] d, e, m);
    if (!w)
      expq.push_back({e, m});
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    vi = irq;
    @(posedge clk);
  endtask

  task automatic flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_idle;
    repeat (400)
    begin
      bus(1'b0, REG_STAT, '0, '0, '0);
      if (v[ST_BUSY] === 1'b0)
        return;
    end
    fails++;
  endtask

  task automatic op(input logic [RDW-1:0] c, input logic [RDW-1:0] ev);
    bus(1'b1, REG_CMD, c, '0, '0);
    wait_idle;
    bus(1'b0, REG_IRQ, '0, ev, 32'hF);
  endtask

  // read checker: oldest note against the answer cycle
  always @(posedge clk)
  begin
    if (rd_d && expq.size() > 0)
    begin
      ent = expq.pop_front();
      if (ent[31:0] != '0)
      begin
        checks_done++;
        if ((reg_rdata & ent[31:0]) !== ent[63:32])
        begin
          fails++;
          $display("BAD t=%0t got %h exp %h", $time,
                   reg_rdata & ent[31:0], ent[63:32]);
        end
      end
    end
    rd_d <= reg_rd;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      stop_test;
    end
  end

  initial
  begin
    clk         = 1'b0;
    rst         = 1'b1;
    {reg_wr, reg_rd, rd_d} = '0;
    reg_addr    = '0;
    reg_wdata   = '0;
    fails       = 0;
    checks_done = 0;
    cyc         = 0;
    lfsr        = 32'hB6B50024;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, REG_STAT, '0, '0, 32'h3);
    bus(1'b0, 8'h24, '0, '0, 32'hFFFF_FFFF);
    lfsr = nxt(lfsr);
    a    = lfsr;
    bus(1'b1, REG_ADDR, a, '0, '0);
    bus(1'b1, REG_CMD, 32'(OP_READ), '0, '0);
    wait_idle;
    flag(irq, 1'b0);
    bus(1'b1, REG_MASK, 32'hF, '0, '0);
    flag(vi, 1'b1);
    bus(1'b0, REG_RDATA, '0, {16'h0, a[15:0] ^ KEY}, 32'hFFFF_FFFF);
    bus(1'b0, REG_IRQ, '0, 32'h1, 32'hF);
    flag(vi, 1'b0);
    lfsr = nxt(lfsr);
    bus(1'b1, REG_WDATA, lfsr, '0, '0);
    op(32'(OP_WRITE), 32'h1);
    flag(flash_u.wr_last === lfsr[DW-1:0], 1'b1);
    flash_u.start(1'b0, 1'b0, 3);
    op(32'(OP_POLL), 32'h1);
    bus(1'b1, REG_RSTW, {16'h0, RST_W}, '0, '0);
    flash_u.start(1'b1, 1'b0, 0);
    op(32'(OP_POLL), 32'h2);
    bus(1'b0, REG_STAT, '0, 32'h2, 32'h3);
    flag(rb_low, 1'b0);
    flash_u.start(1'b0, 1'b1, 0);
    op(32'(OP_RESET), 32'h1);
    flag(rb_low, 1'b0);
    bus(1'b1, REG_ADDR, 32'h3_0000, '0, '0);
    bus(1'b1, REG_WDATA, 32'h0011, '0, '0);
    flash_u.start(1'b0, 1'b1, 0);
    op(32'(OP_CONFIRM), 32'h1);
    bus(1'b0, REG_STAT, '0, 32'h10, 32'h1C);
    op(32'(OP_SECT), 32'h1);
    repeat (350) @(posedge clk);
    op(32'(OP_SECT), 32'h1);
    bus(1'b0, REG_STAT, '0, 32'h20, 32'h20);
    op(32'(OP_SECT) | 32'h10, 32'h1);
    repeat (700) @(posedge clk);
    flag(flash_u.asleep(), 1'b1);
    op(32'(OP_SECT), 32'h4);
    stop_test;
  end
endmodule
